// ==== hw/branch_and_data_transfer_exec.sv ====
`include "exec_defines.svh"
`default_nettype none

// Overview of operation
// - Branch when scratch flag clear, 1/2 cycles.
// - Branch when range error set, flags untouched.
// - Branch when range error clear, 1/2 cycles.
// - Branch when global enable set, flags untouched.
// - Branch when global enable clear, 1/2 cycles.
// - Pointer load then post-increment, two cycles.
// - Pre-decrement pointer then load, two cycles.
// - Load at pointer plus displacement, two cycles.
// - Load from immediate data address, two cycles.
// - Store via pointer then post-increment.
// - Pre-decrement pointer then store, two cycles.
// - Store at pointer plus displacement, two cycles.
// - Store to immediate data address, two cycles.
// - Program memory read, three cycles, optional increment.
// - Push register onto stack, two cycles.
// - Pop stack into register, two cycles.
module branch_and_data_transfer_exec
  import exec_pkg::*;
  #(parameter int PC_WIDTH = 16,
    parameter int AW = 16,
    parameter int DW = 8,
    parameter int REGS = 32)
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Instruction request
  input wire logic ins_valid,
  input wire op_type ins_op,
  input wire ptr_sel_type ins_ptr,
  input wire mode_type ins_mode,
  input wire logic [`REG_ADDR_WIDTH-1:0] ins_reg,
  input wire logic [AW-1:0] ins_k,
  input wire logic [`Q_WIDTH-1:0] ins_q,
  output logic ins_ready,
  output logic ins_done,
  output logic [PC_WIDTH-1:0] program_counter,
  // Status flags
  input wire logic flag_scratch,
  input wire logic flag_range_error,
  input wire logic flag_global_enable,
  // Data memory
  output logic [AW-1:0] dmem_addr,
  output logic [DW-1:0] dmem_wdata,
  output logic dmem_we,
  output logic dmem_re,
  input wire logic [DW-1:0] dmem_rdata,
  // Program memory
  output logic [AW-1:0] pmem_addr,
  output logic pmem_re,
  input wire logic [DW-1:0] pmem_rdata,
  // Register setup and observation
  input wire logic reg_load_en,
  input wire logic [`REG_ADDR_WIDTH-1:0] reg_load_addr,
  input wire logic [DW-1:0] reg_load_data,
  input wire logic [`REG_ADDR_WIDTH-1:0] reg_peek_addr,
  output logic [DW-1:0] reg_peek_data,
  // Pointer setup and observation
  input wire logic ptr_load_en,
  input wire ptr_sel_type ptr_load_sel,
  input wire logic [AW-1:0] ptr_load_value,
  output logic [AW-1:0] ptr_a,
  output logic [AW-1:0] ptr_b,
  output logic [AW-1:0] ptr_c,
  output logic [AW-1:0] stack_ptr
  );

  state_type state;
  state_type next_state;
  op_type cur_op;
  logic [`REG_ADDR_WIDTH-1:0] cur_reg;
  logic [1:0] cnt;

  wire accept = clk_en && ins_valid && ins_ready;
  wire finish = clk_en && (state == st_busy) && (cnt == 2'd0);

  // Instruction class decode.
  wire is_branch = (ins_op == op_branch_on_clear_scratch) ||
                   (ins_op == op_branch_on_range_error) ||
                   (ins_op == op_branch_on_no_range_error) ||
                   (ins_op == op_branch_on_global_enabled) ||
                   (ins_op == op_branch_on_global_masked);
  wire is_ptr_load = (ins_op == op_load_via_pointer);
  wire is_ptr_store = (ins_op == op_write_via_pointer);
  wire is_ofs = (ins_op == op_load_pointer_offset) ||
                (ins_op == op_write_pointer_offset);
  wire is_abs = (ins_op == op_load_absolute) || (ins_op == op_write_absolute);
  wire is_lpm = (ins_op == op_read_program_memory) ||
                (ins_op == op_read_program_memory_r0);
  wire is_push = (ins_op == op_push);
  wire is_pop = (ins_op == op_pop);
  wire is_dload = is_ptr_load || is_pop || (ins_op == op_load_pointer_offset) ||
                  (ins_op == op_load_absolute);
  wire is_dstore = is_ptr_store || is_push || (ins_op == op_write_pointer_offset) ||
                   (ins_op == op_write_absolute);
  wire is_data = is_dload || is_dstore;

  // Branch condition per flag; no branch touches any flag.
  logic cond;
  always_comb
  begin
    cond = 1'b0;
    unique case (ins_op)
      op_branch_on_clear_scratch: cond = !flag_scratch;
      op_branch_on_range_error: cond = flag_range_error;
      op_branch_on_no_range_error: cond = !flag_range_error;
      op_branch_on_global_enabled: cond = flag_global_enable;
      op_branch_on_global_masked: cond = !flag_global_enable;
      default: cond = 1'b0;
    endcase
  end
  wire taken = is_branch && cond;

  wire [PC_WIDTH-1:0] k_ext =
    {{(PC_WIDTH-`K_BRANCH_WIDTH){ins_k[`K_BRANCH_WIDTH-1]}},
     ins_k[`K_BRANCH_WIDTH-1:0]};
  wire [PC_WIDTH-1:0] pc_one = {{(PC_WIDTH-1){1'b0}}, 1'b1};
  wire [PC_WIDTH-1:0] pc_seq = program_counter + pc_one;
  wire [PC_WIDTH-1:0] pc_target = program_counter + k_ext + pc_one;
  wire [PC_WIDTH-1:0] next_pc = taken ? pc_target : pc_seq;

  // Cycle count of the request being accepted.
  wire [1:0] cycles = is_lpm ? `CYC_PROGRAM_READ :
                      is_data ? `CYC_DATA :
                      taken ? `CYC_BRANCH_TAKEN : `CYC_BRANCH_NOT_TAKEN;
  wire single = (cycles == `CYC_BRANCH_NOT_TAKEN);

  // Selected pointer value.
  wire [AW-1:0] ptr_val = (ins_ptr == sel_pointer_pair_a) ? ptr_a :
                          (ins_ptr == sel_pointer_pair_b) ? ptr_b :
                          (ins_ptr == sel_pointer_pair_c) ? ptr_c : stack_ptr;
  wire [AW-1:0] addr_one = {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] q_ext = {{(AW-`Q_WIDTH){1'b0}}, ins_q};
  wire pre_dec = (is_ptr_load || is_ptr_store) && (ins_mode == mode_pre_dec);
  wire post_inc = (is_ptr_load || is_ptr_store || is_lpm) &&
                  (ins_mode == mode_post_inc);

  // Effective data address.
  logic [AW-1:0] next_addr;
  always_comb
  begin
    next_addr = ptr_val;
    if (pre_dec)
      next_addr = ptr_val - addr_one;
    else if (is_ofs)
      next_addr = ptr_val + q_ext;
    else if (is_abs)
      next_addr = ins_k;
    else if (is_push)
      next_addr = stack_ptr;
    else if (is_pop)
      next_addr = stack_ptr + addr_one;
  end

  // Pointer step strobes, issued on the accept edge.
  logic [3:0] step_inc;
  logic [3:0] step_dec;
  logic [3:0] load_hit;
  always_comb
  begin
    step_inc = 4'h0;
    step_dec = 4'h0;
    load_hit = 4'h0;
    load_hit[ptr_load_sel] = ptr_load_en;
    if (accept)
    begin
      if (post_inc && !is_lpm)
        step_inc[ins_ptr] = 1'b1;
      if (post_inc && is_lpm)
        step_inc[sel_pointer_pair_c] = 1'b1;
      if (pre_dec)
        step_dec[ins_ptr] = 1'b1;
      if (is_push)
        step_dec[sel_stack] = 1'b1;
      if (is_pop)
        step_inc[sel_stack] = 1'b1;
    end
  end

  wire [AW-1:0] ptr_vals [4];
  assign ptr_a = ptr_vals[sel_pointer_pair_a];
  assign ptr_b = ptr_vals[sel_pointer_pair_b];
  assign ptr_c = ptr_vals[sel_pointer_pair_c];
  assign stack_ptr = ptr_vals[sel_stack];

  for (genvar i = 0; i < 4; i++)
  begin : g_ptr
    pointer_reg #(.WIDTH(AW)) u_ptr (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .load_en(load_hit[i]),
      .load_value(ptr_load_value),
      .inc(step_inc[i]),
      .dec(step_dec[i]),
      .value(ptr_vals[i])
    );
  end

  // Register file write: a completing load wins over a setup write.
  wire cur_lpm = (cur_op == op_read_program_memory) ||
                 (cur_op == op_read_program_memory_r0);
  wire cur_load = cur_lpm || (cur_op == op_load_via_pointer) ||
                  (cur_op == op_load_pointer_offset) ||
                  (cur_op == op_load_absolute) || (cur_op == op_pop);
  wire core_we = finish && cur_load;
  wire rf_we = core_we || reg_load_en;
  wire [`REG_ADDR_WIDTH-1:0] rf_waddr = core_we ? cur_reg : reg_load_addr;
  wire [DW-1:0] rf_wdata = !core_we ? reg_load_data :
                           cur_lpm ? pmem_rdata : dmem_rdata;
  wire [`REG_ADDR_WIDTH-1:0] src_addr = accept ? ins_reg : cur_reg;

  // Store data come straight from the registered read port.
  reg_file #(.DEPTH(REGS), .WIDTH(DW), .AW(`REG_ADDR_WIDTH)) u_rf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr_a(src_addr),
    .rdata_a(dmem_wdata),
    .raddr_b(reg_peek_addr),
    .rdata_b(reg_peek_data)
  );

  // Sequencer.
  always_comb
  begin
    next_state = state;
    unique case (state)
      st_idle:
        if (accept && !single)
          next_state = st_busy;
      st_busy:
        if (finish)
          next_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= st_idle;
      cnt <= 2'd0;
      cur_op <= op_none;
      cur_reg <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (accept)
      begin
        cnt <= cycles - `CNT_BIAS;
        cur_op <= ins_op;
        cur_reg <= (ins_op == op_read_program_memory_r0) ? `LPM_DEFAULT_DEST : ins_reg;
      end
      else if (state == st_busy && cnt != 2'd0)
        cnt <= cnt - 2'd1;
    end
  end

  // Handshake and program counter.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ins_ready <= 1'b1;
      ins_done <= 1'b0;
      program_counter <= `PC_RESET_VALUE;
    end
    else if (clk_en)
    begin
      ins_done <= (accept && single) || finish;
      if (accept)
        ins_ready <= single;
      else if (finish)
        ins_ready <= 1'b1;
      if (accept)
        program_counter <= next_pc;
    end
  end

  // Memory strobes last one cycle after the accept edge.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dmem_addr <= '0;
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      pmem_addr <= '0;
      pmem_re <= 1'b0;
    end
    else if (clk_en)
    begin
      dmem_we <= accept && is_dstore;
      dmem_re <= accept && is_dload;
      pmem_re <= accept && is_lpm;
      if (accept && is_data)
        dmem_addr <= next_addr;
      if (accept && is_lpm)
        pmem_addr <= ptr_c;
    end
  end

endmodule

`default_nettype wire

// ==== hw/pointer_reg.sv ====
`include "exec_defines.svh"
`default_nettype none

module pointer_reg
  #(parameter int WIDTH = 16)
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Control
  input wire logic load_en,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic inc,
  input wire logic dec,
  // State
  output logic [WIDTH-1:0] value
  );

  // A step from the executing instruction wins over a setup load.
  logic [WIDTH-1:0] next_value;
  assign next_value = inc ? value + {{(WIDTH-1){1'b0}}, 1'b1} :
                      dec ? value - {{(WIDTH-1){1'b0}}, 1'b1} :
                      load_en ? load_value : value;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      value <= `POINTER_RESET_VALUE;
    else if (clk_en)
      value <= next_value;
  end

endmodule

`default_nettype wire

// ==== hw/reg_file.sv ====
`default_nettype none

module reg_file
  #(parameter int DEPTH = 32,
    parameter int WIDTH = 8,
    parameter int AW = 5)
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Registered read ports
  input wire logic [AW-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
  );

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (clk_en && we)
      mem[waddr] <= wdata;
  end

  // Read data are registered; a same-edge write shows one cycle later.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_a <= '0;
      rdata_b <= '0;
    end
    else if (clk_en)
    begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end

endmodule

`default_nettype wire

// ==== pkg/exec_defines.svh ====
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// Cycle counts of each instruction class, counted from the accept edge.
`define CYC_BRANCH_NOT_TAKEN 2'd1
`define CYC_BRANCH_TAKEN 2'd2
`define CYC_DATA 2'd2
`define CYC_PROGRAM_READ 2'd3
// Counter bias: edges after the accept edge before completion is (cycles - 2).
`define CNT_BIAS 2'd2

// Operand field widths.
`define K_BRANCH_WIDTH 7
`define Q_WIDTH 6
`define REG_ADDR_WIDTH 5

// Fixed register numbers and reset values.
`define LPM_DEFAULT_DEST 5'h00
`define PC_RESET_VALUE '0
`define POINTER_RESET_VALUE '0

`endif

// ==== pkg/exec_pkg.sv ====
`default_nettype none

package exec_pkg;

  typedef enum logic [3:0] {
    op_branch_on_clear_scratch    = 4'h0,
    op_branch_on_range_error      = 4'h1,
    op_branch_on_no_range_error   = 4'h2,
    op_branch_on_global_enabled   = 4'h3,
    op_branch_on_global_masked    = 4'h4,
    op_load_via_pointer           = 4'h5,
    op_load_pointer_offset        = 4'h6,
    op_load_absolute              = 4'h7,
    op_write_via_pointer          = 4'h8,
    op_write_pointer_offset       = 4'h9,
    op_write_absolute             = 4'ha,
    op_read_program_memory        = 4'hb,
    op_read_program_memory_r0     = 4'hc,
    op_push                       = 4'hd,
    op_pop                        = 4'he,
    op_none                       = 4'hf
  } op_type;

  typedef enum logic [1:0] {
    sel_pointer_pair_a = 2'h0,
    sel_pointer_pair_b = 2'h1,
    sel_pointer_pair_c = 2'h2,
    sel_stack          = 2'h3
  } ptr_sel_type;

  typedef enum logic [1:0] {
    mode_plain    = 2'h0,
    mode_post_inc = 2'h1,
    mode_pre_dec  = 2'h2
  } mode_type;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } state_type;

endpackage

`default_nettype wire

// ==== testbench/branch_and_data_transfer_exec_bench.sv ====
`default_nettype none

module branch_and_data_transfer_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;

  typedef struct packed {
    logic [3:0] op; logic [1:0] p; logic [1:0] m; logic [4:0] r;
    logic [15:0] k; logic [15:0] ea; logic [15:0] ep; logic [7:0] d;
  } row_type;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ins_valid = 1'b0;
  op_type ins_op = op_none;
  ptr_sel_type ins_ptr = sel_pointer_pair_a;
  mode_type ins_mode = mode_plain;
  logic [4:0] ins_reg = 5'h00;
  logic [4:0] reg_peek_addr = 5'h00;
  logic [15:0] ins_k = 16'h0000;
  logic [5:0] ins_q = 6'h00;
  logic flag_scratch = 1'b0;
  logic flag_range_error = 1'b0;
  logic flag_global_enable = 1'b0;
  logic clk_en = 1'b1;
  logic ptr_load_en = 1'b0;
  ptr_sel_type ptr_load_sel = sel_pointer_pair_a;
  logic [15:0] ptr_load_value = 16'h0000;
  logic ins_ready, ins_done, dmem_we, dmem_re, pmem_re;
  logic [15:0] program_counter, dmem_addr, pmem_addr, ptr_a, ptr_b, ptr_c, stack_ptr;
  logic [7:0] dmem_wdata, dmem_rdata, pmem_rdata, reg_peek_data;
  logic [15:0] exp_pc = 16'h0000;
  logic [15:0] cap = 16'h0000;
  int err_count = 0;
  int n_checks = 0;

  // Fields: op, pointer, mode, register, k or q, address, pointer after, data.
  row_type rows [15] = '{
    '{4'h5, 2'h0, 2'h0, 5'h01, 16'h0000, 16'h0100, 16'h0100, 8'h01},
    '{4'h5, 2'h0, 2'h1, 5'h02, 16'h0000, 16'h0100, 16'h0101, 8'h01},
    '{4'h5, 2'h0, 2'h2, 5'h03, 16'h0000, 16'h0100, 16'h0100, 8'h01},
    '{4'h5, 2'h2, 2'h2, 5'h05, 16'h0000, 16'h02ff, 16'h02ff, 8'hfd},
    '{4'h6, 2'h1, 2'h0, 5'h06, 16'h0005, 16'h0205, 16'h0200, 8'h07},
    '{4'h6, 2'h2, 2'h0, 5'h07, 16'h003f, 16'h033e, 16'h02ff, 8'h3d},
    '{4'h7, 2'h0, 2'h0, 5'h08, 16'h1234, 16'h1234, 16'h0100, 8'h26},
    '{4'he, 2'h3, 2'h0, 5'h09, 16'h0000, 16'h0401, 16'h0401, 8'h05},
    '{4'h8, 2'h0, 2'h1, 5'h05, 16'h0000, 16'h0100, 16'h0101, 8'hfd},
    '{4'h8, 2'h1, 2'h2, 5'h06, 16'h0000, 16'h01ff, 16'h01ff, 8'h07},
    '{4'h9, 2'h2, 2'h0, 5'h07, 16'h0001, 16'h0300, 16'h02ff, 8'h3d},
    '{4'ha, 2'h0, 2'h0, 5'h08, 16'h0abc, 16'h0abc, 16'h0101, 8'h26},
    '{4'hd, 2'h3, 2'h0, 5'h05, 16'h0000, 16'h0401, 16'h0400, 8'hfd},
    '{4'hb, 2'h2, 2'h1, 5'h0a, 16'h0000, 16'h02ff, 16'h0300, 8'h10},
    '{4'hc, 2'h2, 2'h0, 5'h0b, 16'h0000, 16'h0300, 16'h0300, 8'h11}};

  branch_and_data_transfer_exec branch_and_data_transfer_exec_i (.core_clk, .arst_n,
    .clk_en, .ins_valid, .ins_op, .ins_ptr, .ins_mode, .ins_reg, .ins_k, .ins_q,
    .ins_ready, .ins_done, .program_counter, .flag_scratch, .flag_range_error,
    .flag_global_enable, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata,
    .pmem_addr, .pmem_re, .pmem_rdata, .reg_load_en(1'b0), .reg_load_addr(5'h00),
    .reg_load_data(8'h00), .reg_peek_addr, .reg_peek_data, .ptr_load_en, .ptr_load_sel,
    .ptr_load_value, .ptr_a, .ptr_b, .ptr_c, .stack_ptr);

  exec_mem_model exec_mem_model_i (.core_clk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
    .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata);

  always #50 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (dmem_re || dmem_we)
      cap <= dmem_addr;
    if (pmem_re)
      cap <= pmem_addr;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic setp(input logic [1:0] s, input logic [15:0] v);
    @(negedge core_clk);
    ptr_load_en = 1'b1;
    ptr_load_sel = ptr_sel_type'(s);
    ptr_load_value = v;
    @(negedge core_clk);
    ptr_load_en = 1'b0;
  endtask

  // Holding the request for h cycles checks that a busy core refuses it.
  task automatic run(input row_type w, input int h, output int n);
    @(negedge core_clk);
    ins_op = op_type'(w.op);
    ins_ptr = ptr_sel_type'(w.p);
    ins_mode = mode_type'(w.m);
    ins_reg = w.r;
    ins_k = w.k;
    ins_q = w.k[5:0];
    ins_valid = 1'b1;
    repeat (h) @(negedge core_clk);
    ins_valid = 1'b0;
    n = h;
    while (ins_done !== 1'b1 && n < 9)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic do_row(input row_type w, input int h);
    int n;
    logic [7:0] v;
    run(w, h, n);
    exp_pc += 16'h1;
    chk("cycles", (w.op inside {4'hb, 4'hc}) ? 16'h3 : 16'h2, n[15:0]);
    chk("address", w.ea, cap);
    chk("pointer", w.ep, w.p == 2'h0 ? ptr_a : w.p == 2'h1 ? ptr_b
      : w.p == 2'h2 ? ptr_c : stack_ptr);
    chk("pc", exp_pc, program_counter);
    if (w.op inside {4'h8, 4'h9, 4'ha, 4'hd})
      chk("stored", {8'h00, w.d}, {8'h00, exec_mem_model_i.dm[w.ea]});
    else
    begin
      @(negedge core_clk);
      // The default program read form ignores its register field and fills register zero.
      reg_peek_addr = (w.op == 4'hc) ? 5'h00 : w.r;
      repeat (2) @(negedge core_clk);
      v = reg_peek_data;
      chk("loaded", {8'h00, w.d}, {8'h00, v});
    end
  endtask

  initial
  begin
    row_type w;
    int n;
    logic cond;
    logic [15:0] sx;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    setp(2'h0, 16'h0100);
    setp(2'h1, 16'h0200);
    setp(2'h2, 16'h0300);
    setp(2'h3, 16'h0400);
    foreach (rows[i])
      do_row(rows[i], 1);
    $display("data transfer rows done");
    w = '0;
    for (int b = 0; b < 5; b++)
      for (int t = 0; t < 2; t++)
      begin
        cond = t[0];
        flag_scratch = !cond;
        flag_range_error = (b == 2) ? !cond : cond;
        flag_global_enable = (b == 4) ? !cond : cond;
        w.op = b[3:0];
        w.k = b[0] ? 16'h007d : 16'h0005;
        sx = {{9{w.k[6]}}, w.k[6:0]};
        run(w, 1, n);
        exp_pc += cond ? sx + 16'h1 : 16'h1;
        chk("branch pc", exp_pc, program_counter);
        chk("branch cycles", cond ? 16'h2 : 16'h1, n[15:0]);
      end
    $display("branch tests done");
    w = rows[1];
    w.ea = 16'h0101;
    w.ep = 16'h0102;
    w.d = 8'h00;
    do_row(w, 2);
    $display("busy refusal test done");
    @(negedge core_clk);
    arst_n = 1'b0;
    @(negedge core_clk);
    chk("pc in reset", 16'h0000, program_counter);
    chk("ready in reset", 16'h0001, {15'h0000, ins_ready});
    arst_n = 1'b1;
    exp_pc = 16'h0000;
    w.ea = 16'h0000;
    w.ep = 16'h0001;
    w.r = 5'h01;
    do_row(w, 1);
    $display("mid-run reset test done");
    // A pointer load while the clock enable is low must not take effect.
    clk_en = 1'b0;
    setp(2'h0, 16'h0abc);
    chk("frozen pointer", 16'h0001, ptr_a);
    chk("frozen pc", 16'h0001, program_counter);
    clk_en = 1'b1;
    $display("clock enable test done");
    tally_and_finish();
  end

  // The tests need under 150 cycles; this limit of 3000 cycles leaves a wide margin.
  initial
  begin
    #(3000 * 100);
    err_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ==== testbench/exec_mem_model.sv ====
`default_nettype none

module exec_mem_model
  (
  // Clock
  input wire logic core_clk,
  // Data memory
  input wire logic [15:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_we,
  input wire logic dmem_re,
  output logic [7:0] dmem_rdata,
  // Program memory
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_re,
  output logic [7:0] pmem_rdata
  );
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] dm [0:65535];
  logic [7:0] junk = 8'h00;

  initial
  begin
    pmem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++)
    begin
      dm[i] = i[7:0] ^ i[15:8];
    end
  end

  // combinational read
  // Outside a read the data changes every cycle so a late sample shows up.
  assign dmem_rdata = dmem_re ? dm[dmem_addr] : junk;

  always @(posedge core_clk)
  begin
    junk <= junk + 8'h3b;
    if (dmem_we)
      dm[dmem_addr] <= dmem_wdata;
    if (pmem_re)
      pmem_rdata <= pmem_addr[7:0] + 8'h11;
  end
endmodule

`default_nettype wire

// ==== testbench/exec_monitor.sv ====
`default_nettype none

module exec_monitor
  import exec_pkg::*;
  (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Request
  input wire logic ins_valid,
  input wire op_type ins_op,
  input wire ptr_sel_type ins_ptr,
  input wire mode_type ins_mode,
  input wire logic [15:0] ins_k,
  input wire logic [5:0] ins_q,
  input wire logic ins_ready,
  input wire logic ins_done,
  input wire logic [15:0] program_counter,
  // Flags
  input wire logic flag_scratch,
  input wire logic flag_range_error,
  input wire logic flag_global_enable,
  // Memories and pointers
  input wire logic [15:0] dmem_addr,
  input wire logic dmem_we,
  input wire logic dmem_re,
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_re,
  input wire logic [15:0] ptr_a,
  input wire logic [15:0] ptr_b,
  input wire logic [15:0] ptr_c,
  input wire logic [15:0] stack_ptr
  );
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  wire acc = clk_en && ins_valid && ins_ready;
  wire br = ins_op <= op_branch_on_global_masked;
  wire tk = (ins_op == op_branch_on_clear_scratch && !flag_scratch)
    || (ins_op == op_branch_on_range_error && flag_range_error)
    || (ins_op == op_branch_on_no_range_error && !flag_range_error)
    || (ins_op == op_branch_on_global_enabled && flag_global_enable)
    || (ins_op == op_branch_on_global_masked && !flag_global_enable);
  wire [15:0] sx = {{9{ins_k[6]}}, ins_k[6:0]};
  wire [15:0] p = ins_ptr == sel_pointer_pair_a ? ptr_a
    : ins_ptr == sel_pointer_pair_b ? ptr_b : ptr_c;
  wire ldst = ins_op == op_load_via_pointer || ins_op == op_write_via_pointer;
  wire ofs = ins_op == op_load_pointer_offset || ins_op == op_write_pointer_offset;
  wire read_program_memory = ins_op == op_read_program_memory || ins_op == op_read_program_memory_r0;

  chk_taken_pc: assert property (
    acc && br && tk |=> program_counter == $past(program_counter) + $past(sx) + 16'h1
    && !ins_done ##1 ins_done) else $error("taken branch pc or timing wrong");
  chk_fall_pc: assert property (
    acc && br && !tk |=> program_counter == $past(program_counter) + 16'h1 && ins_done)
    else $error("fall-through pc or timing wrong");
  chk_post_inc: assert property (
    acc && ldst && ins_mode == mode_post_inc |=> dmem_addr == $past(p)
    && p == $past(p) + 16'h1 && !ins_done ##1 ins_done) else $error("post-increment wrong");
  chk_pre_dec: assert property (
    acc && ldst && ins_mode == mode_pre_dec |=> dmem_addr == $past(p) - 16'h1
    && p == dmem_addr && !ins_done ##1 ins_done) else $error("pre-decrement wrong");
  chk_offset_hold: assert property (
    acc && ofs |=> dmem_addr == $past(p) + $past(ins_q) && $stable(p) && !ins_done
    ##1 ins_done) else $error("displacement access wrong");
  chk_lpm_fetch: assert property (
    acc && read_program_memory |=> pmem_re && pmem_addr == $past(ptr_c) && !ins_done ##1 !ins_done
    ##1 ins_done) else $error("program read wrong");
  chk_push_stack: assert property (
    acc && ins_op == op_push |=> dmem_we && dmem_addr == $past(stack_ptr)
    && stack_ptr == $past(stack_ptr) - 16'h1) else $error("push wrong");
  chk_pop_stack: assert property (
    acc && ins_op == op_pop |=> dmem_re && dmem_addr == $past(stack_ptr) + 16'h1
    && stack_ptr == dmem_addr) else $error("pop wrong");
endmodule

bind branch_and_data_transfer_exec exec_monitor exec_monitor_i (.core_clk, .arst_n, .clk_en,
  .ins_valid, .ins_op, .ins_ptr, .ins_mode, .ins_k, .ins_q, .ins_ready, .ins_done,
  .program_counter, .flag_scratch, .flag_range_error, .flag_global_enable, .dmem_addr,
  .dmem_we, .dmem_re, .pmem_addr, .pmem_re, .ptr_a, .ptr_b, .ptr_c, .stack_ptr);

`default_nettype wire
